// File: verilog/pllmrc_defs.svh
// Register offsets, field positions, reset values and load timing.
`ifndef PLLMRC_DEFS_SVH
`define PLLMRC_DEFS_SVH

// ============================================================
// Register offsets (byte addresses)
`define PLLMRC_CTRL_OFF 12'h000
`define PLLMRC_BW_OFF 12'h004
`define PLLMRC_SEL_OFF 12'h008
`define PLLMRC_PLAN_OFF 12'h00C
`define PLLMRC_STAT_OFF 12'h010

// ============================================================
// Control fields
`define PLLMRC_CTRL_HARD 0
`define PLLMRC_CTRL_SOFT 1
`define PLLMRC_CTRL_FAST 2
`define PLLMRC_CTRL_AUTO 3

// ============================================================
// Bandwidth codes: normal 0 is 0.1 Hz and 15 is 4 kHz, fast codes
// below 100 Hz are raised to the fast minimum.
`define PLLMRC_FAST_CODE_MIN 4'h8

// ============================================================
// Nonvolatile store contents, loaded one word per cycle
`define PLLMRC_NV_WORDS 4
`define PLLMRC_NV_CTRL 32'h0000_000C
`define PLLMRC_NV_BW 32'h0000_00A4
`define PLLMRC_NV_SEL 32'h0000_0000
`define PLLMRC_NV_PLAN 32'h0001_0001

`endif

// File: verilog/pllmrc_pkg.sv
// Types shared by the mode and reset controller.
package pllmrc_pkg;
   typedef enum logic [2:0] {
      ST_INIT,
      ST_FREERUN,
      ST_ACQ,
      ST_LOCKED,
      ST_HOLD
   } pllmrc_state_t;

   typedef struct packed {
      logic [3:0] fast;
      logic [3:0] norm;
   } pllmrc_bw_t;
endpackage

// File: verilog/pllmrc_ctrl.sv
// PLL mode, reset and initialization controller with APB registers.
`timescale 1ns/1ps
`include "pllmrc_defs.svh"

// How it works
// - Power-up loads registers from nonvolatile store.
// - Bus stalls until initialization has finished.
// - Output clocks stay off during initialization.
// - Hard reset reloads store, resets everything.
// - Hard reset from pin or register bit.
// - Soft reset only commits pending configuration.
// - After init, exactly one of four modes.
// - Normal loop bandwidth set by register code.
// - Fast-lock bandwidth used during acquisition.
// - Back to normal bandwidth once locked.
// - Input selection manual or automatic.
// - Frequency plan writable; hard reset restores the stored value.
// - Free-run entered right after initialization.
// - Valid candidate input starts lock acquisition (auto: any input, manual: the selected one).
// - Selected input lost while locked, no candidate valid: holdover.
// - Holdover exits when a candidate input returns (auto: any, manual: the selected one).
module pllmrc_ctrl (
   input wire logic pclk, // 200 MHz clock
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic hard_reset_pin_n, // Hard reset pin, active low
   input wire logic [3:0] input_valid, // Per input_clock_port validity
   input wire logic lock_detect, // Lock detector report
   output logic clk_out_en, // Output clocks running
   output pllmrc_pkg::pllmrc_state_t pll_mode, // Controller mode
   output logic [1:0] active_input, // Selected input
   output logic [3:0] loop_bw, // Bandwidth code applied to the loop
   output pllmrc_pkg::pllmrc_bw_t active_bw, // Committed bandwidths
   output logic [31:0] freq_plan // Committed frequency plan
);
   import pllmrc_pkg::*;

   localparam logic [31:0] NV_ROM [0:3] = '{`PLLMRC_NV_CTRL,
      `PLLMRC_NV_BW, `PLLMRC_NV_SEL, `PLLMRC_NV_PLAN};
   localparam logic [1:0] NV_LAST = 2'(`PLLMRC_NV_WORDS - 1);

   pllmrc_state_t state_ff, nxt_state;
   logic [1:0] load_idx_ff;
   logic fast_en_ff, auto_sel_ff;
   pllmrc_bw_t bw_pend_ff, nxt_active_bw;
   logic [1:0] man_sel_ff, sel_ff, cand;
   logic [31:0] plan_pend_ff, rd_mux;
   logic acc, done, wr, hit, restart, hr_wr, sr_wr;
   logic loading, cand_ok, sel_valid, reselect;

   // ============================================================
   // APB decode
   assign acc = psel & penable;
   assign done = acc & pready;
   assign wr = done & pwrite;
   assign hr_wr = wr & (paddr == `PLLMRC_CTRL_OFF)
      & pwdata[`PLLMRC_CTRL_HARD];
   assign sr_wr = wr & (paddr == `PLLMRC_CTRL_OFF)
      & pwdata[`PLLMRC_CTRL_SOFT];
   assign restart = ~hard_reset_pin_n | hr_wr;
   assign loading = (state_ff == ST_INIT);

   always_comb
   begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         `PLLMRC_CTRL_OFF: rd_mux = {28'h000_0000, auto_sel_ff,
            fast_en_ff, 2'b00};
         `PLLMRC_BW_OFF: rd_mux = {24'h00_0000, bw_pend_ff};
         `PLLMRC_SEL_OFF: rd_mux = {30'h0000_0000, man_sel_ff};
         `PLLMRC_PLAN_OFF: rd_mux = plan_pend_ff;
         `PLLMRC_STAT_OFF: rd_mux = {16'h0000, active_bw, lock_detect,
            clk_out_en, active_input, 1'b0, state_ff};
         default: hit = 1'b0;
      endcase
   end

   // The slave answers one cycle into the access phase and never
   // during initialization.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= acc & ~pready & ~loading & ~restart;
         if (acc & ~pready)
         begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~hit;
         end
      end
   end

   // ============================================================
   // Nonvolatile load and configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         load_idx_ff <= 2'b00;
      else if (restart)
         load_idx_ff <= 2'b00;
      else if (loading)
         load_idx_ff <= load_idx_ff + 2'b01;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fast_en_ff <= NV_ROM[0][`PLLMRC_CTRL_FAST];
         auto_sel_ff <= NV_ROM[0][`PLLMRC_CTRL_AUTO];
         bw_pend_ff <= NV_ROM[1][7:0];
         man_sel_ff <= NV_ROM[2][1:0];
         plan_pend_ff <= NV_ROM[3];
      end
      else if (loading)
      begin
         // Registers are restored from the store word by word.
         unique case (load_idx_ff)
            2'd0:
            begin
               fast_en_ff <= NV_ROM[0][`PLLMRC_CTRL_FAST];
               auto_sel_ff <= NV_ROM[0][`PLLMRC_CTRL_AUTO];
            end
            2'd1: bw_pend_ff <= NV_ROM[1][7:0];
            2'd2: man_sel_ff <= NV_ROM[2][1:0];
            2'd3: plan_pend_ff <= NV_ROM[3];
         endcase
      end
      else if (wr & ~restart)
      begin
         unique case (paddr)
            `PLLMRC_CTRL_OFF:
            begin
               fast_en_ff <= pwdata[`PLLMRC_CTRL_FAST];
               auto_sel_ff <= pwdata[`PLLMRC_CTRL_AUTO];
            end
            `PLLMRC_BW_OFF:
            begin
               bw_pend_ff.norm <= pwdata[3:0];
               bw_pend_ff.fast <= (pwdata[7:4] < `PLLMRC_FAST_CODE_MIN) ?
                  `PLLMRC_FAST_CODE_MIN : pwdata[7:4];
            end
            `PLLMRC_SEL_OFF: man_sel_ff <= pwdata[1:0];
            `PLLMRC_PLAN_OFF: plan_pend_ff <= pwdata;
            default:
            begin
            end
         endcase
      end
   end

   // Pending settings take effect at a soft reset or when loading ends.
   always_comb
   begin
      nxt_active_bw = active_bw;
      if (sr_wr & ~restart)
         nxt_active_bw = bw_pend_ff;
      else if (loading & (load_idx_ff == NV_LAST))
         nxt_active_bw = bw_pend_ff;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         active_bw <= NV_ROM[1][7:0];
         freq_plan <= NV_ROM[3];
      end
      else
      begin
         active_bw <= nxt_active_bw;
         // The plan word lands in the pending register on this same edge,
         // so the commit at the end of loading takes the store directly.
         if (sr_wr & ~restart)
            freq_plan <= plan_pend_ff;
         else if (loading & (load_idx_ff == NV_LAST))
            freq_plan <= NV_ROM[3];
      end
   end

   // ============================================================
   // Input selection
   always_comb
   begin
      cand = man_sel_ff;
      if (auto_sel_ff)
      begin
         cand = 2'd0;
         for (int i = 3; i >= 0; i--)
            if (input_valid[i])
               cand = 2'(i);
      end
   end

   assign cand_ok = auto_sel_ff ? |input_valid : input_valid[man_sel_ff];
   assign sel_valid = input_valid[sel_ff];

   // ============================================================
   // Mode state machine
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_INIT:
            if (load_idx_ff == NV_LAST)
               nxt_state = ST_FREERUN;
         ST_FREERUN:
            if (cand_ok)
               nxt_state = ST_ACQ;
         ST_ACQ:
            if (!sel_valid)
               nxt_state = cand_ok ? ST_ACQ : ST_FREERUN;
            else if (lock_detect)
               nxt_state = ST_LOCKED;
         ST_LOCKED:
            if (!sel_valid)
               nxt_state = cand_ok ? ST_ACQ : ST_HOLD;
         ST_HOLD:
            if (cand_ok)
               nxt_state = ST_ACQ;
      endcase
      if (restart)
         nxt_state = ST_INIT;
   end

   assign reselect = (nxt_state == ST_ACQ)
      & ((state_ff != ST_ACQ) | ~sel_valid);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_ff <= ST_INIT;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sel_ff <= 2'd0;
      else if (restart)
         sel_ff <= 2'd0;
      else if (reselect)
         sel_ff <= cand;
   end

   // ============================================================
   // Registered outputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clk_out_en <= 1'b0;
         loop_bw <= 4'h0;
      end
      else
      begin
         clk_out_en <= (nxt_state != ST_INIT);
         loop_bw <= ((nxt_state == ST_ACQ) & fast_en_ff) ?
            nxt_active_bw.fast : nxt_active_bw.norm;
      end
   end

   assign pll_mode = state_ff;
   assign active_input = sel_ff;

   // ============================================================
   // Assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_load_run;
      (loading && load_idx_ff == 2'd0 && !restart) ##1 !restart [*3];
   endsequence

   a_bus_init_stall: assert property (
      loading |-> !pready)
      else $error("bus answered during initialization");
   a_clk_off_init: assert property (
      loading |-> !clk_out_en)
      else $error("output clocks ran during initialization");
   a_load_to_free: assert property (
      s_load_run |=> state_ff == ST_FREERUN && clk_out_en)
      else $error("free-run not entered after load");
   a_pin_hard_rst: assert property (
      !hard_reset_pin_n |=> loading && load_idx_ff == 2'd0 && !pready)
      else $error("hard reset pin did not restart");
   a_bit_hard_rst: assert property (
      hr_wr |=> loading ##1 !clk_out_en)
      else $error("hard reset bit did not restart");
   a_soft_commit: assert property (
      (sr_wr && !restart && !loading) |=>
         active_bw == $past(bw_pend_ff) && !loading)
      else $error("soft reset commit wrong");
   a_fast_bw_acq: assert property (
      (state_ff == ST_ACQ && $past(fast_en_ff) && !$past(restart)
         && $past(nxt_state) == ST_ACQ) |-> loop_bw == active_bw.fast)
      else $error("fast-lock bandwidth not applied");
   a_norm_bw_lock: assert property (
      state_ff == ST_LOCKED |-> loop_bw == active_bw.norm)
      else $error("normal bandwidth not restored");
   a_acq_start: assert property (
      (state_ff == ST_FREERUN && cand_ok && !restart) |=>
         state_ff == ST_ACQ && active_input == $past(cand))
      else $error("acquisition did not start");
   a_lock_entry: assert property (
      (state_ff == ST_ACQ && sel_valid && lock_detect && !restart)
         |=> state_ff == ST_LOCKED)
      else $error("lock not entered");
   a_hold_entry: assert property (
      (state_ff == ST_LOCKED && !sel_valid && !cand_ok && !restart)
         |=> state_ff == ST_HOLD)
      else $error("holdover not entered");
   a_hold_exit: assert property (
      (state_ff == ST_HOLD && cand_ok && !restart) |=> state_ff == ST_ACQ)
      else $error("holdover not left");
endmodule

// File: verification/pllmrc_host.sv
// APB host model that drives the controller's register bus.
`timescale 1ns/1ps
module pllmrc_host (
   input wire logic pclk, // Bus clock
   output logic psel, // Select
   output logic penable, // Enable
   output logic pwrite, // Direction
   output logic [11:0] paddr, // Byte address
   output logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr // Error response
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end

   // The host holds each request until pready, so it never talks early.
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines show the inverse so stale values cannot pass.
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// File: verification/tb_pllmrc_ctrl.sv
// Self-checking bench for the mode and reset controller.
`timescale 1ns/1ps
`include "pllmrc_defs.svh"
module tb_pllmrc_ctrl;
   import pllmrc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic hard_reset_pin_n = 1'b1;
   logic [3:0] input_valid = 4'h0;
   logic lock_detect = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, clk_out_en, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, freq_plan, r;
   logic [1:0] active_input;
   logic [3:0] loop_bw;
   pllmrc_state_t pll_mode;
   pllmrc_bw_t active_bw;
   int n_errors = 0;
   int total_checks = 0;

   always #2.5 pclk = ~pclk;

   pllmrc_host pllmrc_host_i (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   pllmrc_ctrl pllmrc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hard_reset_pin_n(hard_reset_pin_n), .input_valid(input_valid),
      .lock_detect(lock_detect), .clk_out_en(clk_out_en),
      .pll_mode(pll_mode), .active_input(active_input), .loop_bw(loop_bw),
      .active_bw(active_bw), .freq_plan(freq_plan));

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      pllmrc_host_i.xfer(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a);
      pllmrc_host_i.xfer(1'b0, a, 32'h0000_0000, r, e);
   endtask

   task automatic drive(input logic [3:0] v, input logic l);
      @(posedge pclk);
      input_valid <= v;
      lock_detect <= l;
      tick(3);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      #20000;
      n_errors++;
      $display("BAD watchdog expired");
      end_of_test();
   end

   initial
   begin
      tick(11);
      chk("mode", pll_mode, ST_INIT);
      chk("clk", clk_out_en, 1'b0);
      @(posedge pclk);
      presetn <= 1'b1;
      tick(1);
      chk("clk", clk_out_en, 1'b0);
      rd(12'h010);
      chk("stat", r, 32'h0000_A441);
      rd(12'h004);
      chk("bw", r, 32'h0000_00A4);
      chk("plan", freq_plan, 32'h0001_0001);
      $display("test init done");
      wr(12'h004, 32'h0000_0053);
      wr(12'h00C, 32'h1234_5678);
      tick(2);
      chk("pend", active_bw, 8'hA4);
      wr(12'h000, 32'h0000_000E);
      tick(2);
      chk("abw", active_bw, 8'h83);
      chk("plan", freq_plan, 32'h1234_5678);
      chk("mode", pll_mode, ST_FREERUN);
      $display("test soft done");
      drive(4'b0110, 1'b0);
      chk("mode", pll_mode, ST_ACQ);
      chk("inp", active_input, 2'd1);
      chk("lbw", loop_bw, 4'h8);
      drive(4'b0110, 1'b1);
      chk("mode", pll_mode, ST_LOCKED);
      chk("lbw", loop_bw, 4'h3);
      drive(4'b0000, 1'b0);
      chk("mode", pll_mode, ST_HOLD);
      drive(4'b0100, 1'b0);
      chk("mode", pll_mode, ST_ACQ);
      chk("inp", active_input, 2'd2);
      $display("test modes done");
      wr(12'h000, 32'h0000_0004);
      wr(12'h008, 32'h0000_0003);
      drive(4'b0000, 1'b0);
      chk("mode", pll_mode, ST_FREERUN);
      drive(4'b0010, 1'b0);
      chk("mode", pll_mode, ST_FREERUN);
      drive(4'b1010, 1'b0);
      chk("inp", active_input, 2'd3);
      wr(12'h000, 32'h0000_0000);
      tick(2);
      chk("mode", pll_mode, ST_ACQ);
      chk("lbw", loop_bw, 4'h3);
      $display("test manual done");
      rd(12'h020);
      chk("err", e, 1'b1);
      chk("rd0", r, 32'h0000_0000);
      wr(12'h010, 32'h0000_0000);
      chk("roerr", e, 1'b0);
      $display("test map done");
      @(posedge pclk);
      hard_reset_pin_n <= 1'b0;
      tick(2);
      chk("mode", pll_mode, ST_INIT);
      chk("clk", clk_out_en, 1'b0);
      chk("inp", active_input, 2'd0);
      @(posedge pclk);
      hard_reset_pin_n <= 1'b1;
      rd(12'h008);
      chk("sel", r, 32'h0000_0000);
      rd(12'h004);
      chk("bw", r, 32'h0000_00A4);
      chk("plan", freq_plan, 32'h0001_0001);
      wr(12'h004, 32'h0000_0051);
      wr(12'h000, 32'h0000_0001);
      tick(2);
      chk("mode", pll_mode, ST_INIT);
      chk("clk", clk_out_en, 1'b0);
      rd(12'h004);
      chk("bw", r, 32'h0000_00A4);
      rd(12'h000);
      chk("ctrl", r, 32'h0000_000C);
      $display("test hard done");
      end_of_test();
   end
endmodule
